// >>> logic/link_supervisor_regs.svh
// Purpose: constants of the link and input supervisor
// Assumes: sys_clk at 125 MHz
// Notes:   times keep their printed figure, counts derive from them
`ifndef LINK_SUPERVISOR_REGS_SVH
`define LINK_SUPERVISOR_REGS_SVH

// ****************************************
// timing
// ****************************************
`define LS_CLK_MHZ          125
`define LS_WD_SHORT_MS      32
`define LS_WD_LONG_MS       128
`define LS_IN_DGL_US        200
`define LS_RST_DGL_US       10
`define LS_REF_DGL_US_X10   20
`define LS_CLK_LOW_HZ       100
`define LS_WD_SHORT_CYC     (`LS_WD_SHORT_MS * `LS_CLK_MHZ * 1000)
`define LS_WD_LONG_CYC      (`LS_WD_LONG_MS * `LS_CLK_MHZ * 1000)
`define LS_IN_DGL_CYC       (`LS_IN_DGL_US * `LS_CLK_MHZ)
`define LS_RST_DGL_CYC      (`LS_RST_DGL_US * `LS_CLK_MHZ)
`define LS_REF_DGL_CYC      ((`LS_REF_DGL_US_X10 * `LS_CLK_MHZ) / 10)
`define LS_CLK_LOW_CYC      ((`LS_CLK_MHZ * 1000000) / `LS_CLK_LOW_HZ)

// ****************************************
// frame layout
// ****************************************
`define LS_FRAME_BITS       16
`define LS_FRAME_TOGGLE_BIT 15

// ****************************************
// register map
// ****************************************
`define LS_CTRL_OFS         8'h00
`define LS_QSTAT1_OFS       8'h04
`define LS_STAT7_OFS        8'h1C
`define LS_CTRL_RST         16'h0000
`define LS_CTRL_CHON_LSB    0
`define LS_CTRL_CH6_BIT     5
`define LS_CTRL_WDSEL_BIT   8
`define LS_QS1_CLKFAIL_BIT  0
`define LS_QS1_CLKBAD_BIT   1
`define LS_ST7_LINKF_BIT    0
`define LS_ST7_REQ_BIT      1
`define LS_ST7_FAIL_BIT     2

`endif

// >>> logic/link_supervisor_pkg.sv
// Purpose: shared types of the link and input supervisor
// Assumes: nothing
// Notes:   constants live in link_supervisor_regs.svh
package link_supervisor_pkg;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b01,
    MODE_FAIL   = 2'b10
  } op_mode_e;

endpackage : link_supervisor_pkg

// >>> logic/deglitch_filter.sv
// Purpose: two-flop synchroniser plus deglitch filter for one pin
// Assumes: pin is asynchronous to sys_clk
// Notes:   RISE_PASS lets rising edges through at once
module deglitch_filter #(
  parameter int unsigned CYCLES    = 250,
  parameter bit          RISE_PASS = 1'b0
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic srst,
  // pin and filtered level
  input  wire logic pin_in,
  output logic      level_out
);

  localparam int unsigned CW = $clog2(CYCLES + 1);

  logic          sync_a_r;
  logic          sync_b_r;
  logic [CW-1:0] cnt_r;

  if (CYCLES < 2) begin : g_bad_cycles
    $error("deglitch_filter: CYCLES must be at least 2");
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sync_a_r <= 1'b0;
      sync_b_r <= 1'b0;
    end else begin
      sync_a_r <= pin_in;
      sync_b_r <= sync_a_r;
    end
  end

  // level changes only after the new value held CYCLES clocks, or at once on a rise when RISE_PASS is set
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      level_out <= 1'b0;
      cnt_r     <= '0;
    end else if (sync_b_r == level_out) begin
      cnt_r <= '0;
    end else if (RISE_PASS && sync_b_r) begin
      level_out <= 1'b1;
      cnt_r     <= '0;
    end else if (cnt_r == CW'(CYCLES - 1)) begin
      level_out <= sync_b_r;
      cnt_r     <= '0;
    end else begin
      cnt_r <= cnt_r + CW'(1);
    end
  end

  a_glitch_blocked: assert property (@(posedge sys_clk) disable iff (srst)
    (!RISE_PASS || !sync_b_r) && sync_b_r != level_out && cnt_r == '0 |=> $stable(level_out))
    else $error("filter output moved on first cycle of a change");

endmodule : deglitch_filter

// >>> logic/link_frame_port.sv
// Purpose: serial link frame port, sampled by sys_clk
// Assumes: link clock far slower than sys_clk, idle low, data sampled on rising edge
// Notes:   only the last 16 bits of a chain-long frame are kept
module link_frame_port (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // link pins
  input  wire logic        cs_n_pin,
  input  wire logic        sck_pin,
  input  wire logic        si_pin,
  output logic             so_out,
  output logic             so_oe,
  // frame side
  input  wire logic [15:0] tx_word,
  output logic             frame_done,
  output logic             frame_len_ok,
  output logic [15:0]      frame_word
);

  logic [2:0]  cs_s_r;
  logic [2:0]  sck_s_r;
  logic [1:0]  si_s_r;
  logic [15:0] rx_sh_r;
  logic [15:0] tx_sh_r;
  logic [3:0]  bit_cnt_r;
  logic        any_bit_r;
  logic        cs_fall;
  logic        cs_rise;
  logic        sck_rise;
  logic        sck_fall;

  // stage 0 of each chain feeds only stage 1
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cs_s_r  <= 3'h7;
      sck_s_r <= 3'h0;
      si_s_r  <= 2'h0;
    end else begin
      cs_s_r  <= {cs_s_r[1:0], cs_n_pin};
      sck_s_r <= {sck_s_r[1:0], sck_pin};
      si_s_r  <= {si_s_r[0], si_pin};
    end
  end

  assign cs_fall  = !cs_s_r[1] && cs_s_r[2];
  assign cs_rise  = cs_s_r[1] && !cs_s_r[2];
  assign sck_rise = !cs_s_r[1] && sck_s_r[1] && !sck_s_r[2];
  assign sck_fall = !cs_s_r[1] && !sck_s_r[1] && sck_s_r[2];

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rx_sh_r   <= 16'h0000;
      bit_cnt_r <= 4'h0;
      any_bit_r <= 1'b0;
    end else if (cs_fall) begin
      bit_cnt_r <= 4'h0;
      any_bit_r <= 1'b0;
    end else if (sck_rise) begin
      rx_sh_r   <= {rx_sh_r[14:0], si_s_r[1]};
      bit_cnt_r <= bit_cnt_r + 4'h1;
      any_bit_r <= 1'b1;
    end
  end

  // modulo 16 check: the 4-bit counter wraps to zero on every full word
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      frame_done   <= 1'b0;
      frame_len_ok <= 1'b0;
      frame_word   <= 16'h0000;
    end else begin
      frame_done <= cs_rise && any_bit_r;
      if (cs_rise) begin
        frame_len_ok <= bit_cnt_r == 4'h0;
        frame_word   <= rx_sh_r;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tx_sh_r <= 16'h0000;
      so_out  <= 1'b0;
      so_oe   <= 1'b0;
    end else if (cs_fall) begin
      tx_sh_r <= tx_word;
      so_out  <= tx_word[15];
      so_oe   <= 1'b1;
    end else if (cs_rise) begin
      so_oe <= 1'b0;
    end else if (sck_fall) begin
      tx_sh_r <= {tx_sh_r[14:0], 1'b0};
      so_out  <= tx_sh_r[14];
    end
  end

endmodule : link_frame_port

// >>> logic/link_and_input_supervisor.sv
// Purpose: link watchdog, input deglitchers, clock supervision, output steering
// Assumes: pins asynchronous to sys_clk; pwm_level comes from logic on sys_clk
// Notes:   active_low_reset_in low acts as a soft reset of the supervision state
//
// The address map and strobed register access were chosen for this implementation.
`include "link_supervisor_regs.svh"

module link_and_input_supervisor #(
  parameter int unsigned WD_SHORT_CYC = `LS_WD_SHORT_CYC,
  parameter int unsigned WD_LONG_CYC  = `LS_WD_LONG_CYC,
  parameter int unsigned IN_DGL_CYC   = `LS_IN_DGL_CYC,
  parameter int unsigned CLK_LOW_CYC  = `LS_CLK_LOW_CYC
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // serial link pins
  input  wire logic        link_cs_n,
  input  wire logic        link_sck,
  input  wire logic        link_si,
  output logic             link_so,
  output logic             link_so_oe,
  // direct pins
  input  wire logic        failmode_request_in,
  input  wire logic [3:0]  direct_channel_inputs,
  input  wire logic        active_low_reset_in,
  input  wire logic        ref_clk_in,
  // pwm engine levels
  input  wire logic [4:0]  pwm_level,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata,
  // outputs
  output logic [4:0]       power_out,
  output logic             external_switch_drive,
  output logic             fail_mode_out
);

  localparam int unsigned RST_DGL_CYC = `LS_RST_DGL_CYC;
  localparam int unsigned REF_DGL_CYC = `LS_REF_DGL_CYC;
  localparam int unsigned WDW         = $clog2(WD_LONG_CYC + 1);
  localparam int unsigned CLW         = $clog2(CLK_LOW_CYC + 1);

  if (WD_SHORT_CYC < 2 || WD_LONG_CYC < WD_SHORT_CYC) begin : g_bad_wd
    $error("watchdog counts must be at least 2 and long not below short");
  end
  if (CLK_LOW_CYC <= 2 * REF_DGL_CYC) begin : g_bad_clk
    $error("CLK_LOW_CYC must exceed two reference deglitch times");
  end

  // ****************************************
  // input deglitchers
  // ****************************************
  logic       failmode_request_filtered;
  logic [3:0] direct_channel_filtered;
  logic       rst_in_filtered;
  logic       ref_filtered;
  logic       rst_low;

  deglitch_filter #(.CYCLES(IN_DGL_CYC), .RISE_PASS(1'b0)) u_req_dgl (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .pin_in    (failmode_request_in),
    .level_out (failmode_request_filtered)
  );

  for (genvar i = 0; i < 4; i++) begin : g_dir_dgl
    deglitch_filter #(.CYCLES(IN_DGL_CYC), .RISE_PASS(1'b0)) u_dir (
      .sys_clk   (sys_clk),
      .srst      (srst),
      .pin_in    (direct_channel_inputs[i]),
      .level_out (direct_channel_filtered[i])
    );
  end

  // rising edge passes at once, so only the fall is delayed
  deglitch_filter #(.CYCLES(RST_DGL_CYC), .RISE_PASS(1'b1)) u_rst_dgl (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .pin_in    (active_low_reset_in),
    .level_out (rst_in_filtered)
  );

  // too fast a clock never survives the filter and reads as missing
  deglitch_filter #(.CYCLES(REF_DGL_CYC), .RISE_PASS(1'b0)) u_ref_dgl (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .pin_in    (ref_clk_in),
    .level_out (ref_filtered)
  );

  assign rst_low = !rst_in_filtered;

  // ****************************************
  // serial frames
  // ****************************************
  logic        frame_done;
  logic        frame_len_ok;
  logic [15:0] frame_word;
  logic [15:0] stat7_word;

  link_frame_port u_frame (
    .sys_clk      (sys_clk),
    .srst         (srst),
    .cs_n_pin     (link_cs_n),
    .sck_pin      (link_sck),
    .si_pin       (link_si),
    .so_out       (link_so),
    .so_oe        (link_so_oe),
    .tx_word      (stat7_word),
    .frame_done   (frame_done),
    .frame_len_ok (frame_len_ok),
    .frame_word   (frame_word)
  );

  // ****************************************
  // fault detection
  // ****************************************
  logic           last_toggle_r;
  logic           toggle_seen_r;
  logic           toggle_ok;
  logic           good_frame;
  logic           toggle_err;
  logic           len_err;
  logic           wd_timeout;
  logic           link_fault_evt;
  logic [WDW-1:0] wd_cnt_r;
  logic [WDW-1:0] wd_limit;
  logic [15:0]    ctrl_r;

  // a stuck data line repeats the toggle bit, so no separate check exists
  assign toggle_ok  = !toggle_seen_r || (frame_word[`LS_FRAME_TOGGLE_BIT] != last_toggle_r);
  assign good_frame = frame_done && frame_len_ok && toggle_ok;
  assign toggle_err = frame_done && frame_len_ok && !toggle_ok;
  assign len_err    = frame_done && !frame_len_ok;
  assign wd_limit   = ctrl_r[`LS_CTRL_WDSEL_BIT] ? WDW'(WD_LONG_CYC - 1) : WDW'(WD_SHORT_CYC - 1);
  assign wd_timeout = wd_cnt_r >= wd_limit;
  assign link_fault_evt = toggle_err || len_err || wd_timeout;

  always_ff @(posedge sys_clk) begin
    if (srst || rst_low) begin
      last_toggle_r <= 1'b0;
      toggle_seen_r <= 1'b0;
    end else if (good_frame) begin
      last_toggle_r <= frame_word[`LS_FRAME_TOGGLE_BIT];
      toggle_seen_r <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst || rst_low) begin
      wd_cnt_r <= '0;
    end else if (good_frame || wd_timeout) begin
      wd_cnt_r <= '0;
    end else begin
      wd_cnt_r <= wd_cnt_r + WDW'(1);
    end
  end

  // ****************************************
  // operating mode and link fault flag
  // ****************************************
  link_supervisor_pkg::op_mode_e mode_r;
  link_supervisor_pkg::op_mode_e mode_nxt;
  logic                          link_fault_flag_r;
  logic                          leave_fail;

  // leaving fail needs the request gone and a clean frame
  assign leave_fail = mode_r == link_supervisor_pkg::MODE_FAIL && !failmode_request_filtered
                      && good_frame && !link_fault_evt;

  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      link_supervisor_pkg::MODE_NORMAL: begin
        if (link_fault_evt || failmode_request_filtered) begin
          mode_nxt = link_supervisor_pkg::MODE_FAIL;
        end
      end
      link_supervisor_pkg::MODE_FAIL: begin
        if (leave_fail) begin
          mode_nxt = link_supervisor_pkg::MODE_NORMAL;
        end
      end
      default: begin
        mode_nxt = link_supervisor_pkg::MODE_FAIL;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst || rst_low) begin
      mode_r <= link_supervisor_pkg::MODE_NORMAL;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // a fresh fault wins over the clear on the way out of fail
  always_ff @(posedge sys_clk) begin
    if (srst || rst_low) begin
      link_fault_flag_r <= 1'b0;
    end else if (link_fault_evt) begin
      link_fault_flag_r <= 1'b1;
    end else if (leave_fail) begin
      link_fault_flag_r <= 1'b0;
    end
  end

  assign stat7_word = {13'h0000, mode_r == link_supervisor_pkg::MODE_FAIL,
                       failmode_request_filtered, link_fault_flag_r};

  // ****************************************
  // reference clock supervision
  // ****************************************
  logic           ref_d_r;
  logic [CLW-1:0] ref_cnt_r;
  logic           clk_bad_r;
  logic           clock_fail_r;
  logic           qs1_read;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ref_d_r <= 1'b0;
    end else begin
      ref_d_r <= ref_filtered;
    end
  end

  // held idle in reset, so timing starts at the reset release
  always_ff @(posedge sys_clk) begin
    if (srst || rst_low) begin
      ref_cnt_r <= '0;
      clk_bad_r <= 1'b0;
    end else if (ref_filtered && !ref_d_r) begin
      ref_cnt_r <= '0;
      clk_bad_r <= 1'b0;
    end else if (ref_cnt_r == CLW'(CLK_LOW_CYC - 1)) begin
      clk_bad_r <= 1'b1;
    end else begin
      ref_cnt_r <= ref_cnt_r + CLW'(1);
    end
  end

  assign qs1_read = reg_rd && reg_addr == `LS_QSTAT1_OFS;

  // a read only clears once the condition has gone
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      clock_fail_r <= 1'b0;
    end else if (clk_bad_r) begin
      clock_fail_r <= 1'b1;
    end else if (qs1_read) begin
      clock_fail_r <= 1'b0;
    end
  end

  // ****************************************
  // register port
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl_r <= `LS_CTRL_RST;
    end else if (reg_wr && reg_addr == `LS_CTRL_OFS) begin
      ctrl_r <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reg_rdata <= 16'h0000;
    end else if (!reg_rd) begin
      reg_rdata <= 16'h0000;
    end else if (reg_addr == `LS_CTRL_OFS) begin
      reg_rdata <= ctrl_r;
    end else if (reg_addr == `LS_QSTAT1_OFS) begin
      reg_rdata <= {14'h0000, clk_bad_r, clock_fail_r};
    end else if (reg_addr == `LS_STAT7_OFS) begin
      reg_rdata <= stat7_word;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // ****************************************
  // output steering
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      power_out             <= 5'h00;
      external_switch_drive <= 1'b0;
      fail_mode_out         <= 1'b0;
    end else begin
      fail_mode_out <= mode_r == link_supervisor_pkg::MODE_FAIL;
      if (mode_r == link_supervisor_pkg::MODE_FAIL) begin
        power_out             <= {1'b0, direct_channel_filtered};
        external_switch_drive <= 1'b0;
      end else begin
        external_switch_drive <= ctrl_r[`LS_CTRL_CH6_BIT];
        if (clk_bad_r) begin
          power_out <= ctrl_r[`LS_CTRL_CHON_LSB +: 5];
        end else begin
          power_out <= pwm_level;
        end
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_fault_to_fail: assert property (@(posedge sys_clk) disable iff (srst)
    !rst_low && link_fault_evt |=> mode_r == link_supervisor_pkg::MODE_FAIL)
    else $error("link fault did not enter fail mode");

  a_toggle_repeat: assert property (@(posedge sys_clk) disable iff (srst)
    !rst_low && toggle_seen_r && frame_done && frame_len_ok
    && frame_word[`LS_FRAME_TOGGLE_BIT] == last_toggle_r |=> link_fault_flag_r)
    else $error("repeated toggle bit not flagged");

  a_wd_expiry: assert property (@(posedge sys_clk) disable iff (srst || rst_low)
    wd_cnt_r == WDW'(WD_SHORT_CYC - 1) && !ctrl_r[`LS_CTRL_WDSEL_BIT] |=> link_fault_flag_r && wd_cnt_r == '0)
    else $error("short watchdog expiry missed");

  a_len_fault: assert property (@(posedge sys_clk) disable iff (srst)
    !rst_low && frame_done && !frame_len_ok |=> link_fault_flag_r
    && mode_r == link_supervisor_pkg::MODE_FAIL)
    else $error("bad frame length not flagged");

  a_flag_in_fail: assert property (@(posedge sys_clk) disable iff (srst || rst_low)
    link_fault_flag_r && mode_r == link_supervisor_pkg::MODE_FAIL ##1
    mode_r == link_supervisor_pkg::MODE_FAIL |-> link_fault_flag_r)
    else $error("link fault flag dropped inside fail mode");

  a_flag_exit_clear: assert property (@(posedge sys_clk) disable iff (srst || rst_low)
    mode_r == link_supervisor_pkg::MODE_FAIL ##1 mode_r == link_supervisor_pkg::MODE_NORMAL
    |-> !link_fault_flag_r)
    else $error("link fault flag survived return to normal");

  a_request_fail: assert property (@(posedge sys_clk) disable iff (srst)
    !rst_low && failmode_request_filtered |=> mode_r == link_supervisor_pkg::MODE_FAIL)
    else $error("filtered request did not force fail mode");

  a_fail_direct: assert property (@(posedge sys_clk) disable iff (srst)
    mode_r == link_supervisor_pkg::MODE_FAIL |=> power_out == {1'b0, $past(direct_channel_filtered)}
    && !external_switch_drive)
    else $error("fail mode outputs not from direct inputs");

  a_ext_normal: assert property (@(posedge sys_clk) disable iff (srst)
    mode_r == link_supervisor_pkg::MODE_NORMAL |=> external_switch_drive == $past(ctrl_r[`LS_CTRL_CH6_BIT]))
    else $error("external drive not following channel 6 bit");

  a_clkfail_hold: assert property (@(posedge sys_clk) disable iff (srst)
    clock_fail_r && (clk_bad_r || !qs1_read) |=> clock_fail_r)
    else $error("clock fail cleared without recovery and read");

  a_slow_clk_out: assert property (@(posedge sys_clk) disable iff (srst)
    mode_r == link_supervisor_pkg::MODE_NORMAL && clk_bad_r |=> power_out == $past(ctrl_r[4:0]))
    else $error("outputs not on on/off bits under slow clock");

  a_clk_sup_start: assert property (@(posedge sys_clk) disable iff (srst)
    rst_low |=> ref_cnt_r == '0 && !clk_bad_r)
    else $error("clock supervision ran during reset");

endmodule : link_and_input_supervisor

// >>> verification/link_host_model.sv
// Purpose: host side of the serial link, master of frames
// Assumes: link clock period 64 ns, idle low
// Notes:   a released data line shows the inverse of its last bit
module link_host_model (
  // link pins
  output logic        cs_n,
  output logic        sck,
  output logic        si,
  input  wire logic   so,
  // answer shifted in during the last frame
  output logic [15:0] rx
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
    rx   = 16'h0000;
  end
  // n not a multiple of 16 makes a length fault on purpose
  task automatic send(input int n, input logic [15:0] w);
    cs_n = 1'b0;
    #64;
    for (int i = n - 1; i >= 0; i--) begin
      si = w[i % 16];
      #32 sck = 1'b1;
      rx = {rx[14:0], so};
      #32 sck = 1'b0;
    end
    #32 cs_n = 1'b1;
    si = ~si;
    #64;
  endtask : send
endmodule : link_host_model

// >>> verification/link_and_input_supervisor_bench.sv
// Purpose: self-checking bench of the link and input supervisor
// Assumes: shortened watchdog, filter and clock-low counts
// Notes:   random values from an xorshift seeded at 97
`include "link_supervisor_regs.svh"
module link_and_input_supervisor_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk, srst, cs_n, sck, si, so, req, rst_in, ref_clk, wr_s, rd_s, ext, fm, tg, fast, oe;
  logic [3:0]  din, dq;
  logic [4:0]  pwm, pout;
  logic [7:0]  addr;
  logic [15:0] wdata, rdata, rx, v, c;
  logic [31:0] seed;
  int          n_fail, n_checks;
  link_and_input_supervisor #(.WD_SHORT_CYC(4000), .WD_LONG_CYC(16000), .IN_DGL_CYC(20), .CLK_LOW_CYC(2000)) dut (
    .sys_clk(sys_clk), .srst(srst), .link_cs_n(cs_n), .link_sck(sck), .link_si(si), .link_so(so),
    .link_so_oe(oe), .failmode_request_in(req), .direct_channel_inputs(din), .active_low_reset_in(rst_in),
    .ref_clk_in(ref_clk), .pwm_level(pwm), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr_s),
    .reg_rd(rd_s), .reg_rdata(rdata), .power_out(pout), .external_switch_drive(ext), .fail_mode_out(fm));
  link_host_model host (.cs_n(cs_n), .sck(sck), .si(si), .so(so), .rx(rx));
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge sys_clk);
    wr_s  <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge sys_clk);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask : rd
  task automatic good();
    logic [31:0] r;
    r = xs();
    fork
      host.send(16, {tg, r[14:0]});
      begin
        tick(20);
        chk("so_oe", 16'h0001, {15'h0, oe});
      end
    join
    tg = ~tg;
    tick(8);
    chk("so_oe_idle", 16'h0000, {15'h0, oe});
  endtask : good
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop
  // ****************************************
  // clocks and watchdog
  // ****************************************
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // fast toggling is swallowed by the filter and must read as a dead clock
  initial begin
    ref_clk = 1'b0;
    forever begin
      // fast is unknown at time zero; an unknown delay would spin forever
      #((fast === 1'b1) ? 8 : 4800);
      ref_clk = ~ref_clk;
    end
  end
  initial begin
    tick(60000);
    n_fail++;
    report_and_stop();
  end
  // ****************************************
  // tests
  // ****************************************
  initial begin
    {srst, rst_in, seed, tg, fast, req, din, dq, pwm, addr, wdata, wr_s, rd_s} = {2'b11, 32'h61, 42'h0};
    n_fail = 0;
    n_checks = 0;
    tick(16);
    srst <= 1'b0;
    tick(8);
    rd(`LS_CTRL_OFS, v);
    chk("ctrl_reset", `LS_CTRL_RST, v);
    wr(`LS_STAT7_OFS, 16'hFFFF);
    rd(8'h10, v);
    chk("unmapped", 16'h0000, v);
    good();
    good();
    rd(`LS_STAT7_OFS, v);
    chk("stat7_idle", 16'h0000, v);
    $display("test registers done");
    req <= 1'b1;
    tick(10);
    chk("req_early", 16'h0000, {15'h0, fm});
    tick(30);
    chk("req_fail", 16'h0001, {15'h0, fm});
    rd(`LS_STAT7_OFS, v);
    chk("req_bit", 16'h0001, {15'h0, v[1]});
    req <= 1'b0;
    tick(40);
    good();
    chk("req_exit", 16'h0000, {15'h0, fm});
    $display("test request done");
    fast = 1'b1;
    tick(2600);
    rd(`LS_QSTAT1_OFS, v);
    chk("clk_bad", 16'h0003, {14'h0, v[1:0]});
    c = xs();
    wr(`LS_CTRL_OFS, c & 16'h001F);
    tick(4);
    chk("clk_bad_out", {11'h0, c[4:0]}, {11'h0, pout});
    good();
    fast = 1'b0;
    tick(1500);
    rd(`LS_QSTAT1_OFS, v);
    chk("clk_sticky", 16'h0001, {14'h0, v[1:0]});
    rd(`LS_QSTAT1_OFS, v);
    chk("clk_clear", 16'h0000, {14'h0, v[1:0]});
    $display("test ref clock done");
    repeat (4) begin
      c = xs();
      wr(`LS_CTRL_OFS, c & 16'h003F);
      pwm <= c[12:8];
      tick(4);
      chk("ext_drive", {15'h0, c[5]}, {15'h0, ext});
      chk("pwm_out", {11'h0, c[12:8]}, {11'h0, pout});
    end
    wr(`LS_CTRL_OFS, 16'h0020);
    $display("test steering done");
    for (int k = 0; k < 3; k++) begin
      good();
      if (k == 0) begin
        host.send(16, {16{~tg}});
      end else if (k == 1) begin
        host.send(17, {tg, 15'h0000});
      end else begin
        tick(3950);
        chk("wd_early", 16'h0000, {15'h0, fm});
        tick(100);
      end
      tick(8);
      chk("fail", 16'h0001, {15'h0, fm});
      chk("ext_fail", 16'h0000, {15'h0, ext});
      c = xs();
      din <= c[3:0];
      tick(8);
      chk("din_hold", {11'h0, 1'b0, dq}, {11'h0, pout});
      tick(40);
      chk("din_out", {11'h0, 1'b0, c[3:0]}, {11'h0, pout});
      dq = c[3:0];
      rd(`LS_STAT7_OFS, v);
      chk("stat7_fail", 16'h0005, {13'h0, v[2:0]});
      good();
      chk("so_word", 16'h0005, {13'h0, rx[2:0]});
      chk("fail_exit", 16'h0000, {15'h0, fm});
      rd(`LS_STAT7_OFS, v);
      chk("stat7_exit", 16'h0000, {13'h0, v[2:0]});
      $display("test link fault %0d done", k);
    end
    wr(`LS_CTRL_OFS, 16'h0100);
    good();
    tick(15900);
    chk("wd_long_early", 16'h0000, {15'h0, fm});
    tick(200);
    chk("wd_long", 16'h0001, {15'h0, fm});
    rst_in <= 1'b0;
    tick(100);
    rst_in <= 1'b1;
    tick(10);
    chk("rst_glitch", 16'h0001, {15'h0, fm});
    rst_in <= 1'b0;
    tick(1400);
    rst_in <= 1'b1;
    tick(10);
    chk("rst_soft", 16'h0000, {15'h0, fm});
    wr(`LS_CTRL_OFS, 16'h0000);
    good();
    $display("test long watchdog done");
    report_and_stop();
  end
endmodule : link_and_input_supervisor_bench
